// file: core/acv_ctrl.sv
// Converter control: register slave, sequencing, result processing.
// Assumes the analog macro delivers a 12-bit code on ana_data that
// is valid at the last convert tick, and that all inputs are
// synchronous to clk.
`timescale 1ns/100ps
// Function
// - Resolution selectable 8, 10 or 12 bits; lower takes fewer ticks.
// - A single undecimated result is left or right aligned as configured.
// - Differential results are signed, single-ended unsigned.
// - Conversion starts on a software command or an event.
// - Exactly one event input triggers a conversion.
// - Positive input 0..24 and negative input 0..9 are selectable.
// - Gain is selectable from one half to sixteen.
// - Results on a chosen channel are compared to window thresholds.
// - Reference is chosen by a four-bit setting.
// - Samples can be accumulated and decimated to 16 bits.
// - Gain and offset errors are corrected in hardware.
// - Conversion continues in sleep while the clock runs.
// - Pending flags raise a request that can wake the system.
// - Result and window events go out while asleep.
// - Control and input writes take effect at a converter tick.
// - Debug halt stops conversion unless debug-run is set.
// - Protection blocks all writes except the flag register.
// - Debugger writes pass protection.
// - Writing the start bit launches a conversion.
// - Free-running restarts at the end of each conversion.
// - New result overwrites; unread result raises overrun.
// - Soft reset returns all but the debug register to reset values and disables.
module acv_ctrl (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM register slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event system and interrupt request.
  input wire logic evt_start,
  output logic evt_result_ready_flag,
  output logic evt_winmon,
  output logic irq,
  // Debug and access protection.
  input wire logic dbg_halt,
  input wire logic dbg_access,
  input wire logic prot_en,
  // Analog macro.
  input wire logic [11:0] ana_data,
  output logic ana_sample,
  output logic ana_convert,
  output logic [4:0] mux_pos,
  output logic [4:0] mux_neg,
  output logic [3:0] gain_sel,
  output logic [3:0] ref_sel,
  output logic diff_mode,
  output logic [15:0] trim_value
);

  typedef struct packed {
    logic wait_r;
    logic [31:0] rdata;
    logic [10:0] ctrl;
    logic [10:0] ctrl_sh;
    logic [17:0] inp;
    logic [17:0] inp_sh;
    logic sync_pend;
    logic start_pend;
    logic [5:0] samplen;
    logic [6:0] avg;
    logic [6:0] win;
    logic [15:0] winlt;
    logic [15:0] winut;
    logic [11:0] gcorr;
    logic [11:0] ocorr;
    logic [15:0] trim;
    logic dbgrun;
    logic [3:0] flags;
    logic [15:0] result;
    logic [9:0] pcnt;
    acv_pkg::acv_st_t st;
    logic [5:0] cnt;
    logic [27:0] acc;
    logic [10:0] nacc;
    logic ana_samp;
    logic ana_conv;
    logic evt_res;
    logic evt_win;
    logic irq;
  } acv_state_t;

  acv_state_t s_r;
  acv_state_t s_nxt;

  // Reset image; the debug-run bit is passed in so soft reset keeps it.
  function automatic acv_state_t rst_val(logic dbg);
    acv_state_t r;
    r = '0;
    r.wait_r = 1'b1;
    r.gcorr = acv_pkg::GC_ONE;
    r.st = acv_pkg::ST_IDLE;
    r.dbgrun = dbg;
    return r;
  endfunction : rst_val

  // Byte-lane merge of a write into the current word.
  function automatic logic [31:0] merge(logic [31:0] cur,
                                        logic [31:0] wd,
                                        logic [3:0] be);
    logic [31:0] r;
    r = cur;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Result width in bits for a resolution code.
  function automatic logic [4:0] res_bits(logic [1:0] rs);
    case (rs)
      acv_pkg::RS_10: res_bits = acv_pkg::RB_10;
      acv_pkg::RS_8: res_bits = acv_pkg::RB_8;
      default: res_bits = acv_pkg::RB_12;
    endcase
  endfunction : res_bits

  // Keeps the top bits of the code, signed when differential.
  function automatic logic signed [16:0] samp_val(logic [11:0] d,
                                                  logic [1:0] rs,
                                                  logic dif);
    logic [4:0] sh;
    sh = acv_pkg::RB_FULL - res_bits(rs);
    if (dif) begin
      samp_val = $signed({d[11], d, 4'h0}) >>> sh;
    end else begin
      samp_val = $signed({1'b0, d, 4'h0}) >>> sh;
    end
  endfunction : samp_val

  // Reserved selections are refused so the mux never sees them.
  function automatic logic inp_ok(logic [17:0] v);
    logic [3:0] g;
    g = v[acv_pkg::I_GAIN +: 4];
    inp_ok = (v[acv_pkg::I_POS +: 5] <= acv_pkg::POS_MAX) &&
             (v[acv_pkg::I_NEG +: 5] <= acv_pkg::NEG_MAX) &&
             (g <= acv_pkg::G_MAX || g == acv_pkg::G_DIV2);
  endfunction : inp_ok

  // Window test: 1 above low, 2 below high, 3 inside both.
  function automatic logic win_hit(logic [1:0] m,
                                   logic signed [16:0] v,
                                   logic signed [16:0] lt,
                                   logic signed [16:0] ut);
    case (m)
      2'h1: win_hit = v > lt;
      2'h2: win_hit = v < ut;
      2'h3: win_hit = (v > lt) && (v < ut);
      default: win_hit = 1'b0;
    endcase
  endfunction : win_hit

  // Decoded bus strobes; a write lands only on the accepting edge.
  logic req;
  logic rd_go;
  logic wr_go;
  logic wr_ok;
  logic [31:0] wv;
  assign req = avs_read || avs_write;
  assign rd_go = avs_read && !s_r.wait_r;
  assign wr_go = avs_write && !s_r.wait_r;
  assign wr_ok = wr_go && (!prot_en || dbg_access ||
                 avs_address == acv_pkg::A_FLAG);

  // Converter tick; no sleep input gates it, only a debug halt.
  logic run;
  logic tick;
  logic en;
  logic dif;
  logic [9:0] lim;
  assign run = !(dbg_halt && !s_r.dbgrun);
  assign lim = 10'((acv_pkg::PRE_BASE <<
                    s_r.ctrl[acv_pkg::C_PRE +: 3]) - 10'h001);
  assign tick = run && s_r.pcnt == lim;
  assign en = s_r.ctrl[acv_pkg::C_EN];
  assign dif = s_r.ctrl[acv_pkg::C_DIFF];

  // Sample path: truncate, correct, accumulate, decimate.
  logic signed [16:0] smp;
  logic signed [17:0] d18;
  logic signed [30:0] prod;
  logic signed [30:0] psh;
  logic signed [16:0] cval;
  logic signed [27:0] acc_n;
  logic signed [27:0] rsh;
  logic [3:0] nlog;
  logic [4:0] shift;
  logic [4:0] lsh;
  logic last;
  logic fin;
  logic [15:0] r16;
  logic hit;
  assign smp = samp_val(ana_data, s_r.ctrl[acv_pkg::C_RES +: 2], dif);
  assign d18 = {smp[16], smp} - {{6{s_r.ocorr[11]}}, s_r.ocorr};
  assign prod = d18 * $signed({1'b0, s_r.gcorr});
  assign psh = prod >>> acv_pkg::GC_SHIFT;
  assign cval = s_r.ctrl[acv_pkg::C_CORR] ? psh[16:0] : smp;
  assign acc_n = $signed(s_r.acc) + {{11{cval[16]}}, cval};
  assign nlog = (s_r.avg[3:0] > acv_pkg::SN_MAX) ? acv_pkg::SN_MAX
                : s_r.avg[3:0];
  assign shift = ((nlog > acv_pkg::SN_FREE) ?
                  {1'b0, nlog - acv_pkg::SN_FREE} : 5'h00) +
                 {2'h0, s_r.avg[acv_pkg::V_ADJ +: 3]};
  assign rsh = acc_n >>> shift;
  assign lsh = acv_pkg::RB_FULL - res_bits(s_r.ctrl[acv_pkg::C_RES +: 2]);
  assign last = s_r.nacc == 11'((11'h001 << nlog) - 11'h001);
  assign fin = tick && s_r.st == acv_pkg::ST_CONV && s_r.cnt == '0;
  // Alignment only makes sense for a single undecimated sample.
  assign r16 = (s_r.ctrl[acv_pkg::C_LEFT] && nlog == '0 &&
                shift == '0) ? 16'(cval[15:0] << lsh)
               : rsh[15:0];
  assign hit = win_hit(s_r.win[1:0],
                       dif ? {r16[15], r16} : {1'b0, r16},
                       dif ? {s_r.winlt[15], s_r.winlt}
                           : {1'b0, s_r.winlt},
                       dif ? {s_r.winut[15], s_r.winut}
                           : {1'b0, s_r.winut}) &&
               s_r.win[acv_pkg::W_CH +: 5] ==
               s_r.inp[acv_pkg::I_POS +: 5];

  // Next-state logic for the whole block.
  always_comb begin
    logic [3:0] fset;
    logic [3:0] fclr;
    fset = '0;
    fclr = '0;
    s_nxt = s_r;
    s_nxt.evt_res = 1'b0;
    s_nxt.evt_win = 1'b0;
    // One wait cycle, then accept; read data is loaded with it.
    s_nxt.wait_r = !(req && s_r.wait_r);
    if (req && s_r.wait_r) begin
      case (avs_address)
        acv_pkg::A_CTRL: s_nxt.rdata = 32'(s_r.ctrl_sh);
        acv_pkg::A_INP: s_nxt.rdata = 32'(s_r.inp_sh);
        acv_pkg::A_SAMP: s_nxt.rdata = 32'(s_r.samplen);
        acv_pkg::A_AVG: s_nxt.rdata = 32'(s_r.avg);
        acv_pkg::A_WIN: s_nxt.rdata = 32'(s_r.win);
        acv_pkg::A_WINLT: s_nxt.rdata = 32'(s_r.winlt);
        acv_pkg::A_WINUT: s_nxt.rdata = 32'(s_r.winut);
        acv_pkg::A_GAIN: s_nxt.rdata = 32'(s_r.gcorr);
        acv_pkg::A_OFFS: s_nxt.rdata = 32'(s_r.ocorr);
        acv_pkg::A_TRIM: s_nxt.rdata = 32'(s_r.trim);
        acv_pkg::A_FLAG: s_nxt.rdata = 32'(s_r.flags);
        acv_pkg::A_STAT: s_nxt.rdata = 32'({s_r.sync_pend,
                                   s_r.st != acv_pkg::ST_IDLE});
        acv_pkg::A_RES: s_nxt.rdata = 32'(s_r.result);
        acv_pkg::A_DBG: s_nxt.rdata = 32'(s_r.dbgrun);
        default: s_nxt.rdata = '0;
      endcase
    end
    // Prescaler; it freezes during a debug halt.
    if (run) begin
      s_nxt.pcnt = tick ? '0 : s_r.pcnt + 10'h001;
    end
    // Shadowed settings move over only at a converter tick.
    if (tick && s_r.sync_pend) begin
      s_nxt.ctrl = s_r.ctrl_sh;
      s_nxt.inp = s_r.inp_sh;
      s_nxt.sync_pend = 1'b0;
      fset[acv_pkg::F_SYNC] = 1'b1;
    end
    // Conversion sequencer.
    case (s_r.st)
      acv_pkg::ST_IDLE: begin
        if (tick && en && s_r.start_pend) begin
          s_nxt.st = acv_pkg::ST_SAMP;
          s_nxt.cnt = s_r.samplen;
          s_nxt.start_pend = 1'b0;
        end
      end
      acv_pkg::ST_SAMP: begin
        if (tick && s_r.cnt == '0) begin
          s_nxt.st = acv_pkg::ST_CONV;
          s_nxt.cnt = 6'((res_bits(s_r.ctrl[acv_pkg::C_RES +: 2]) >> 1)
                         - 5'h01);
        end else if (tick) begin
          s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      acv_pkg::ST_CONV: begin
        if (fin) begin
          s_nxt.acc = last ? '0 : acc_n;
          s_nxt.nacc = last ? '0 : s_r.nacc + 11'h001;
          if (last) begin
            s_nxt.result = r16;
            fset[acv_pkg::F_RDY] = 1'b1;
            fset[acv_pkg::F_OVR] = s_r.flags[acv_pkg::F_RDY];
            fset[acv_pkg::F_WIN] = hit;
            s_nxt.evt_res = 1'b1;
            s_nxt.evt_win = hit;
          end
          // Averaging keeps going; free-running restarts on its own.
          if (!last || s_r.ctrl[acv_pkg::C_FREE]) begin
            s_nxt.st = acv_pkg::ST_SAMP;
            s_nxt.cnt = s_r.samplen;
          end else begin
            s_nxt.st = acv_pkg::ST_IDLE;
          end
        end else if (tick) begin
          s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      default: s_nxt.st = acv_pkg::ST_IDLE;
    endcase
    if (!en) begin
      s_nxt.st = acv_pkg::ST_IDLE;
      s_nxt.start_pend = 1'b0;
      s_nxt.acc = '0;
      s_nxt.nacc = '0;
    end
    // Start requests arrive after the sequencer so none is lost.
    if (en && evt_start) begin
      s_nxt.start_pend = 1'b1;
    end
    // Reading the result acknowledges it.
    if (rd_go && avs_address == acv_pkg::A_RES) begin
      fclr[acv_pkg::F_RDY] = 1'b1;
    end
    // Register writes.
    if (wr_ok) begin
      case (avs_address)
        acv_pkg::A_CTRL: begin
          wv = merge(32'(s_r.ctrl_sh), avs_writedata, avs_byteenable);
          s_nxt.ctrl_sh = wv[10:0];
          s_nxt.sync_pend = 1'b1;
        end
        acv_pkg::A_INP: begin
          wv = merge(32'(s_r.inp_sh), avs_writedata, avs_byteenable);
          if (inp_ok(wv[17:0])) begin
            s_nxt.inp_sh = wv[17:0];
            s_nxt.sync_pend = 1'b1;
          end
        end
        acv_pkg::A_SAMP: begin
          wv = merge(32'(s_r.samplen), avs_writedata, avs_byteenable);
          s_nxt.samplen = wv[5:0];
        end
        acv_pkg::A_AVG: begin
          wv = merge(32'(s_r.avg), avs_writedata, avs_byteenable);
          s_nxt.avg = wv[6:0];
        end
        acv_pkg::A_WIN: begin
          wv = merge(32'(s_r.win), avs_writedata, avs_byteenable);
          s_nxt.win = wv[6:0];
        end
        acv_pkg::A_WINLT: begin
          wv = merge(32'(s_r.winlt), avs_writedata, avs_byteenable);
          s_nxt.winlt = wv[15:0];
        end
        acv_pkg::A_WINUT: begin
          wv = merge(32'(s_r.winut), avs_writedata, avs_byteenable);
          s_nxt.winut = wv[15:0];
        end
        acv_pkg::A_GAIN: begin
          wv = merge(32'(s_r.gcorr), avs_writedata, avs_byteenable);
          s_nxt.gcorr = wv[11:0];
        end
        acv_pkg::A_OFFS: begin
          wv = merge(32'(s_r.ocorr), avs_writedata, avs_byteenable);
          s_nxt.ocorr = wv[11:0];
        end
        acv_pkg::A_TRIM: begin
          wv = merge(32'(s_r.trim), avs_writedata, avs_byteenable);
          s_nxt.trim = wv[15:0];
        end
        acv_pkg::A_TRIG: begin
          wv = merge(32'h0, avs_writedata, avs_byteenable);
          s_nxt.start_pend = s_nxt.start_pend ||
                             (en && wv[acv_pkg::T_START]);
        end
        acv_pkg::A_FLAG: begin
          wv = merge(32'h0, avs_writedata, avs_byteenable);
          fclr = fclr | wv[3:0];
        end
        acv_pkg::A_DBG: begin
          wv = merge(32'(s_r.dbgrun), avs_writedata, avs_byteenable);
          s_nxt.dbgrun = wv[0];
        end
        default: wv = '0;
      endcase
    end else begin
      wv = '0;
    end
    // Hardware set beats a software clear in the same cycle.
    s_nxt.flags = (s_r.flags & ~fclr) | fset;
    // Soft reset acts at once, not through the shadow.
    if (wr_ok && avs_address == acv_pkg::A_CTRL &&
        avs_byteenable[0] && avs_writedata[acv_pkg::C_SWRST]) begin
      s_nxt = rst_val(s_r.dbgrun);
    end
    s_nxt.irq = |s_nxt.flags;
    s_nxt.ana_samp = s_nxt.st == acv_pkg::ST_SAMP;
    s_nxt.ana_conv = s_nxt.st == acv_pkg::ST_CONV;
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= rst_val(1'b0);
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.wait_r;
  assign evt_result_ready_flag = s_r.evt_res;
  assign evt_winmon = s_r.evt_win;
  assign irq = s_r.irq;
  assign ana_sample = s_r.ana_samp;
  assign ana_convert = s_r.ana_conv;
  assign mux_pos = s_r.inp[acv_pkg::I_POS +: 5];
  assign mux_neg = s_r.inp[acv_pkg::I_NEG +: 5];
  assign gain_sel = s_r.inp[acv_pkg::I_GAIN +: 4];
  assign ref_sel = s_r.inp[acv_pkg::I_REF +: 4];
  assign diff_mode = s_r.ctrl[acv_pkg::C_DIFF];
  assign trim_value = s_r.trim;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sw_start: assert property (
    wr_ok && avs_address == acv_pkg::A_TRIG && en &&
    avs_byteenable[0] && avs_writedata[acv_pkg::T_START] &&
    !(avs_writedata[acv_pkg::C_SWRST]) |=>
    s_r.start_pend || s_r.st != acv_pkg::ST_IDLE)
    else $error("Software start was not latched.");
  a_evt_start: assert property (
    en && evt_start && !wr_go |=>
    s_r.start_pend || s_r.st != acv_pkg::ST_IDLE)
    else $error("Event start was not latched.");
  a_sync_apply: assert property (
    $fell(s_r.sync_pend) |-> $past(tick) &&
    s_r.ctrl == $past(s_r.ctrl_sh))
    else $error("Shadow copied outside a converter tick.");
  a_prot_block: assert property (
    wr_go && prot_en && !dbg_access &&
    avs_address == acv_pkg::A_TRIM |=> $stable(s_r.trim))
    else $error("Protected write was not blocked.");
  a_dbg_write: assert property (
    wr_go && prot_en && dbg_access && avs_byteenable == 4'hf &&
    avs_address == acv_pkg::A_TRIM |=> s_r.trim == $past(avs_writedata[15:0]))
    else $error("Debugger write was blocked.");
  a_halt_stop: assert property (
    dbg_halt && !s_r.dbgrun |-> !tick ##1 $stable(s_r.cnt))
    else $error("Converter ticked during debug halt.");
  a_overrun_set: assert property (
    fin && last && s_r.flags[acv_pkg::F_RDY] && en |=>
    s_r.flags[acv_pkg::F_OVR] && s_r.evt_res)
    else $error("Unread result did not raise overrun.");
  a_free_run: assert property (
    fin && last && en && s_r.ctrl[acv_pkg::C_FREE] && !wr_go |=>
    s_r.st == acv_pkg::ST_SAMP ##1 s_r.ana_samp)
    else $error("Free-running did not restart.");
  a_swrst_keep: assert property (
    wr_ok && avs_address == acv_pkg::A_CTRL && avs_byteenable[0] &&
    avs_writedata[acv_pkg::C_SWRST] |=> !en && s_r.flags == '0 &&
    s_r.dbgrun == $past(s_r.dbgrun))
    else $error("Soft reset left state behind.");
  a_bus_answer: assert property (
    req && s_r.wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not one cycle wide.");

  c_single: cover property (s_r.st == acv_pkg::ST_CONV ##1 fin && last);
  c_overrun: cover property ($rose(s_r.flags[acv_pkg::F_OVR]));
  c_window: cover property (s_r.evt_win);
  c_average: cover property (fin && !last ##[1:400] fin && last);

endmodule : acv_ctrl

// file: dv/acv_ana_model.sv
// Behavioural analog macro that answers the control block's phases.
// Assumes ana_convert is high for the whole conversion phase.
`timescale 1ns/100ps
module acv_ana_model #(
  parameter logic [11:0] CODE = 12'h5a3
) (
  // Clock and phase.
  input wire logic clk,
  input wire logic ana_convert,
  // Code to the control block.
  output logic [11:0] ana_data
);
  logic flip = 1'b0;
  // Outside conversion the code flips every cycle, so stale use shows.
  always_ff @(posedge clk) begin
    flip <= !flip;
  end
  assign ana_data = ana_convert ? CODE : (CODE ^ {12{flip}});
endmodule : acv_ana_model

// file: dv/adc_conversion_control_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the analog model returns CODE during every conversion.
`timescale 1ns/100ps
module adc_conversion_control_tb_top;
  localparam logic [11:0] CODE = 12'h5a3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd_s = 1'b0, wr_s = 1'b0, evt = 1'b0, dba = 1'b0, prt = 1'b0;
  logic hlt = 1'b0;
  logic [31:0] wd = 32'h0, q;
  logic [31:0] rdd;
  logic wrq, erdy, irq_o, cnv, wmon, dfm;
  logic [4:0] mp, mn;
  logic [3:0] gs, rs;
  logic [15:0] tv;
  logic [11:0] ad;
  int errors = 0, n_tests = 0, lat = 0;
  acv_ctrl dut_u (.clk(clk), .rst(rst), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdd), .avs_waitrequest(wrq),
    .evt_start(evt), .evt_result_ready_flag(erdy), .evt_winmon(wmon), .irq(irq_o),
    .dbg_halt(hlt), .dbg_access(dba), .prot_en(prt), .ana_data(ad),
    .ana_sample(), .ana_convert(cnv), .mux_pos(mp), .mux_neg(mn),
    .gain_sel(gs), .ref_sel(rs), .diff_mode(dfm), .trim_value(tv));
  acv_ana_model #(.CODE(CODE)) ana_u (.clk(clk), .ana_convert(cnv),
    .ana_data(ad));
  // Free-running clock at 50 MHz.
  initial begin
    forever #10 clk = !clk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // A spent bound counts as a mismatch and ends the run at once.
  task automatic bound(int k, string nm);
    if (k >= 300) begin
      chk(nm, 32'h0, 32'h1);
      finish_test();
    end
  endtask : bound
  // One Avalon access; the request is held until waitrequest is low.
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (wrq !== 1'b0 && k < 300);
    q = rdd;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    bound(k, "waitrequest");
    @(posedge clk);
  endtask : bus
  // Poll STATUS until the write crossing into the tick domain is done.
  task automatic wsync();
    int k;
    k = 0;
    do begin
      bus(1'b0, acv_pkg::A_STAT, 32'h0);
      k++;
    end while (q[1] !== 1'b0 && k < 300);
    bound(k, "sync busy");
  endtask : wsync
  task automatic wevt();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (erdy !== 1'b1 && k < 300);
    lat = k;
    bound(k, "result event");
  endtask : wevt
  task automatic s_regs();
    bus(1'b0, acv_pkg::A_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    bus(1'b1, acv_pkg::A_TRIM, 32'h1234);
    bus(1'b0, acv_pkg::A_TRIM, 32'h0);
    chk("trim", 32'h1234, q);
    chk("trim pin", 32'h1234, {16'h0, tv});
    bus(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, q);
    prt <= 1'b1;
    bus(1'b1, acv_pkg::A_TRIM, 32'h0bad);
    bus(1'b0, acv_pkg::A_TRIM, 32'h0);
    chk("protected trim", 32'h1234, q);
    dba <= 1'b1;
    bus(1'b1, acv_pkg::A_TRIM, 32'h4321);
    dba <= 1'b0;
    bus(1'b0, acv_pkg::A_TRIM, 32'h0);
    chk("debugger trim", 32'h4321, q);
    prt <= 1'b0;
  endtask : s_regs
  task automatic s_inp();
    bus(1'b1, acv_pkg::A_INP, 32'h14443);
    wsync();
    chk("mux", 32'h0302, {mp, 3'h0, mn});
    chk("gain ref", 32'h15, {gs, rs});
    bus(1'b1, acv_pkg::A_INP, 32'h00019);
    bus(1'b1, acv_pkg::A_INP, 32'h01400);
    bus(1'b0, acv_pkg::A_INP, 32'h0);
    chk("inp refused", 32'h14443, q);
  endtask : s_inp
  task automatic s_sw();
    bus(1'b1, acv_pkg::A_CTRL, 32'h2);
    wsync();
    bus(1'b1, acv_pkg::A_TRIG, 32'h2);
    wevt();
    bus(1'b0, acv_pkg::A_RES, 32'h0);
    chk("sw result", {20'h0, CODE}, q);
    bus(1'b0, acv_pkg::A_FLAG, 32'h0);
    chk("ready cleared", 32'h0, {31'h0, q[0]});
  endtask : s_sw
  task automatic s_evt();
    evt <= 1'b1;
    @(posedge clk);
    evt <= 1'b0;
    wevt();
    bus(1'b0, acv_pkg::A_RES, 32'h0);
    chk("evt result", {20'h0, CODE}, q);
  endtask : s_evt
  task automatic s_ovr();
    bus(1'b1, acv_pkg::A_TRIG, 32'h2);
    wevt();
    bus(1'b1, acv_pkg::A_TRIG, 32'h2);
    wevt();
    bus(1'b0, acv_pkg::A_FLAG, 32'h0);
    chk("overrun", 32'h3, {30'h0, q[1:0]});
    chk("irq", 32'h1, {31'h0, irq_o});
    prt <= 1'b1;
    bus(1'b1, acv_pkg::A_FLAG, 32'hf);
    bus(1'b0, acv_pkg::A_FLAG, 32'h0);
    chk("flags cleared", 32'h0, q);
    prt <= 1'b0;
  endtask : s_ovr
  // Window above 0x100 on channel 3, the selected positive input.
  task automatic s_left();
    bus(1'b1, acv_pkg::A_WIN, 32'hd);
    bus(1'b1, acv_pkg::A_WINLT, 32'h100);
    bus(1'b1, acv_pkg::A_CTRL, 32'ha);
    wsync();
    bus(1'b1, acv_pkg::A_TRIG, 32'h2);
    wevt();
    chk("window event", 32'h1, {31'h0, wmon});
    bus(1'b0, acv_pkg::A_RES, 32'h0);
    chk("left result", {16'h0, CODE, 4'h0}, q);
  endtask : s_left
  // Four samples are summed; no automatic shift up to sixteen samples.
  task automatic s_avg();
    bus(1'b1, acv_pkg::A_AVG, 32'h2);
    bus(1'b1, acv_pkg::A_TRIG, 32'h2);
    wevt();
    bus(1'b0, acv_pkg::A_RES, 32'h0);
    chk("avg result", {18'h0, CODE, 2'h0}, q);
    bus(1'b1, acv_pkg::A_AVG, 32'h0);
  endtask : s_avg
  // Eight-bit differential code with offset 0x100 and half gain.
  task automatic s_fmt();
    bus(1'b1, acv_pkg::A_OFFS, 32'h100);
    bus(1'b1, acv_pkg::A_GAIN, 32'h400);
    bus(1'b1, acv_pkg::A_CTRL, 32'hb2);
    wsync();
    chk("diff pin", 32'h1, {31'h0, dfm});
    bus(1'b1, acv_pkg::A_TRIG, 32'h2);
    wevt();
    bus(1'b0, acv_pkg::A_RES, 32'h0);
    // (0x5a - 0x100) / 2 is -83, shown as a signed 16-bit word.
    chk("corrected result", 32'hffad, q);
  endtask : s_fmt
  task automatic s_free();
    int k;
    k = 0;
    bus(1'b1, acv_pkg::A_CTRL, 32'h6);
    wsync();
    bus(1'b1, acv_pkg::A_TRIG, 32'h2);
    wevt();
    wevt();
    // One sample tick and six convert ticks, four clocks each.
    chk("free period", 32'h1c, lat);
    // A debug halt freezes the converter; release lets it resume.
    hlt <= 1'b1;
    repeat (60) begin
      @(posedge clk);
      if (erdy !== 1'b0) begin
        k++;
      end
    end
    chk("halted events", 32'h0, k);
    hlt <= 1'b0;
    wevt();
  endtask : s_free
  task automatic s_swrst();
    bus(1'b1, acv_pkg::A_DBG, 32'h1);
    bus(1'b1, acv_pkg::A_CTRL, 32'h1);
    bus(1'b0, acv_pkg::A_CTRL, 32'h0);
    chk("ctrl after reset", 32'h0, q);
    bus(1'b0, acv_pkg::A_TRIM, 32'h0);
    chk("trim after reset", 32'h0, q);
    bus(1'b0, acv_pkg::A_DBG, 32'h0);
    chk("debug kept", 32'h1, q);
  endtask : s_swrst
  // Main sequence: reset for three cycles, then every scenario once.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    s_regs();
    s_inp();
    s_sw();
    s_evt();
    s_ovr();
    s_left();
    s_avg();
    s_fmt();
    s_free();
    s_swrst();
    finish_test();
  end
endmodule : adc_conversion_control_tb_top

// file: include/acv_pkg.sv
// Shared constants for the converter control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package acv_pkg;
  // Register byte offsets, one 32-bit word each.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INP = 8'h04;
  localparam logic [7:0] A_SAMP = 8'h08;
  localparam logic [7:0] A_AVG = 8'h0c;
  localparam logic [7:0] A_WIN = 8'h10;
  localparam logic [7:0] A_WINLT = 8'h14;
  localparam logic [7:0] A_WINUT = 8'h18;
  localparam logic [7:0] A_GAIN = 8'h1c;
  localparam logic [7:0] A_OFFS = 8'h20;
  localparam logic [7:0] A_TRIM = 8'h24;
  localparam logic [7:0] A_TRIG = 8'h28;
  localparam logic [7:0] A_FLAG = 8'h2c;
  localparam logic [7:0] A_STAT = 8'h30;
  localparam logic [7:0] A_RES = 8'h34;
  localparam logic [7:0] A_DBG = 8'h38;
  // Control word fields.
  localparam int C_SWRST = 0;
  localparam int C_EN = 1;
  localparam int C_FREE = 2;
  localparam int C_LEFT = 3;
  localparam int C_DIFF = 4;
  localparam int C_CORR = 5;
  localparam int C_RES = 6;
  localparam int C_PRE = 8;
  // Input selection fields.
  localparam int I_POS = 0;
  localparam int I_NEG = 5;
  localparam int I_GAIN = 10;
  localparam int I_REF = 14;
  localparam logic [4:0] POS_MAX = 5'h18;
  localparam logic [4:0] NEG_MAX = 5'h09;
  localparam logic [3:0] G_MAX = 4'h4;
  localparam logic [3:0] G_DIV2 = 4'hf;
  // Window, averaging, trigger and flag fields.
  localparam int W_CH = 2;
  localparam int V_ADJ = 4;
  localparam logic [3:0] SN_MAX = 4'ha;
  localparam logic [3:0] SN_FREE = 4'h4;
  localparam int T_START = 1;
  localparam int F_RDY = 0;
  localparam int F_OVR = 1;
  localparam int F_WIN = 2;
  localparam int F_SYNC = 3;
  // Resolution codes and their widths in bits.
  localparam logic [1:0] RS_10 = 2'h1;
  localparam logic [1:0] RS_8 = 2'h2;
  localparam logic [4:0] RB_12 = 5'h0c;
  localparam logic [4:0] RB_10 = 5'h0a;
  localparam logic [4:0] RB_8 = 5'h08;
  localparam logic [4:0] RB_FULL = 5'h10;
  // Gain correction of 1.0 and its fraction width; base divide.
  localparam logic [11:0] GC_ONE = 12'h800;
  localparam int GC_SHIFT = 11;
  localparam logic [9:0] PRE_BASE = 10'h004;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMP, ST_CONV} acv_st_t;
endpackage : acv_pkg
